/* File: common/flash_seq_regs.vh */
// Register map, field positions and timing for the program flash sequencer
`ifndef FLASH_SEQ_REGS_VH
`define FLASH_SEQ_REGS_VH
`define OFS_ADDR_LOW   8'h00
`define OFS_ADDR_HIGH  8'h04
`define OFS_DATA_LOW   8'h08
`define OFS_DATA_HIGH  8'h0c
`define OFS_CONTROL    8'h10
`define OFS_UNLOCK     8'h14
`define BIT_READ       0
`define BIT_GO         1
`define BIT_PROGRAM_ENABLE_LATCH       2
`define BIT_ERASE      4
`define BIT_LATCH      5
`define BIT_CONFIG_SPACE_SELECT       6
`define BIT_PGD        7
`define KEY_FIRST      8'h55
`define KEY_SECOND     8'haa
`define LATCH_ERASED   14'h3fff
`define LATCH_COUNT    32
`define LAST_LATCH     5'h1f
`define SETUP_CYCLES   2'h2
`define PROG_TIME_NS   2000000
`define CLK_PERIOD_NS  8
`define TIMER_W        18
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define PROT_NONE      13'h0000
`define PROT_BOOT      13'h0200
`define PROT_HALF      13'h1000
`define PROT_ALL       13'h1fff
`endif

/* File: hw/busy_timer.v */
// Down counter that times an erase or program pulse
`timescale 1ns/1ps
module busy_timer #(
   parameter CYCLES = 250000
) (
   input  wire clk,
   input  wire rst,
   input  wire start,
   output wire done
);
`include "flash_seq_regs.vh"
   localparam [`TIMER_W-1:0] LOAD = CYCLES;
   reg [`TIMER_W-1:0] cnt_q;

   assign done = (cnt_q == {{(`TIMER_W-1){1'b0}}, 1'b1});

   always @(posedge clk) begin
      if (rst) begin
         cnt_q <= {`TIMER_W{1'b0}};
      end else if (start) begin
         cnt_q <= LOAD;
      end else if (cnt_q != {`TIMER_W{1'b0}}) begin
         cnt_q <= cnt_q - {{(`TIMER_W-1){1'b0}}, 1'b1};
      end
   end
endmodule

/* File: hw/flash_seq.v */
// Program flash access sequencer with AXI4-Lite register access
// Contract
// - Read takes the second instruction cycle; that instruction is skipped.
// - Read word lands in data registers next cycle, held until reread or overwrite.
// - Program reads work regardless of code protection.
// - Erase needs address, selects, enable, key 55h then AAh, then go.
// - Erase select clears when the single-row erase finishes.
// - Two setup cycles after go; software places two no-ops. The code holds ST_SETUP for three cycles (setup_q 0 to 2) before it stalls.
// - Erase halts the core about 2 ms; clocks keep running.
// - Write never erases; targets must already be blank.
// - At most 32 words per write, aligned, never crossing the block.
// - Completed write resets every latch to all ones.
// - Latch-only mode just loads one latch, no program, no stall.
// - Commit loads the last latch and programs the whole block.
// - Block write stalls about 2 ms only on the committing word.
// - Read start and go only set by software, cleared by hardware.
// - Go refused unless write enable already set.
// - Erase or write only into unprotected segments.
// - Program select chooses flash; clear selects EEPROM, reset default.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "flash_seq_regs.vh"
module flash_seq #(
   parameter PROG_CYCLES = `PROG_TIME_NS / `CLK_PERIOD_NS
) (
   input  wire        CORE_CLK,
   input  wire        RST,
   input  wire [7:0]  S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output wire        S_AXI_AWREADY,
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output wire        S_AXI_WREADY,
   output wire [1:0]  S_AXI_BRESP,
   output wire        S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   input  wire [7:0]  S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output wire        S_AXI_ARREADY,
   output wire [31:0] S_AXI_RDATA,
   output wire [1:0]  S_AXI_RRESP,
   output wire        S_AXI_RVALID,
   input  wire        S_AXI_RREADY,
   output wire        CORE_SKIP,
   output wire        CORE_STALL,
   output wire [14:0] FLASH_ADDR,
   output wire        FLASH_RD_EN,
   input  wire [13:0] FLASH_RDATA,
   output wire        FLASH_ERASE,
   output wire        FLASH_PROG_EN,
   output wire [13:0] FLASH_WDATA,
   input  wire [1:0]  WRT_PROT
);

   localparam [2:0] ST_IDLE  = 3'b000;
   localparam [2:0] ST_RDISS = 3'b001;
   localparam [2:0] ST_RDCAP = 3'b010;
   localparam [2:0] ST_SETUP = 3'b011;
   localparam [2:0] ST_PROG  = 3'b100;
   localparam [2:0] ST_WAIT  = 3'b101;

   localparam [1:0] KEY_NONE = 2'b00;
   localparam [1:0] KEY_HALF = 2'b01;
   localparam [1:0] KEY_FULL = 2'b10;

   // Bus side state
   reg        aw_held_q;
   reg [7:0]  aw_addr_q;
   reg        w_held_q;
   reg [31:0] w_data_q;
   reg [3:0]  w_strb_q;
   reg        bvalid_q;
   reg [1:0]  bresp_q;
   reg        rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0]  rresp_q;

   // Software visible registers
   reg [7:0]  addr_low_reg_q;
   reg [6:0]  addr_high_reg_q;
   reg [7:0]  data_low_reg_q;
   reg [5:0]  data_high_reg_q;
   reg        read_start_q;
   reg        program_go_q;
   reg        program_enable_latch_q;
   reg        row_erase_select_q;
   reg        latch_only_mode_q;
   reg        config_space_select_q;
   reg        program_space_select_q;
   reg [1:0]  key_q;

   // Sequencer state
   reg [2:0]  state_q;
   reg [1:0]  setup_q;
   reg [4:0]  idx_q;
   reg        op_erase_q;
   reg        stall_q;
   reg        skip_q;
   reg        rd_en_q;
   reg        erase_q;
   reg        prog_q;
   reg [14:0] faddr_q;
   reg [13:0] fwdata_q;

   // Fuse inputs come from outside, so two flops first
   reg [1:0]  wrt_meta_q;
   reg [1:0]  wrt_sync_q;
   reg [12:0] prot_limit;

   wire        wr_fire;
   wire        rd_fire;
   wire [7:0]  wbyte;
   wire        ctl_wr;
   wire        go_ok;
   wire [14:0] word_addr;
   wire        flash_target;
   wire        protected_hit;
   wire        latch_load;
   wire        latch_fill;
   wire [13:0] latch_rdata;
   wire        t_start;
   wire        t_done;
   reg [31:0]  rd_mux;
   reg         rd_hit;

   assign S_AXI_AWREADY = ~aw_held_q;
   assign S_AXI_WREADY  = ~w_held_q;
   assign S_AXI_BVALID  = bvalid_q;
   assign S_AXI_BRESP   = bresp_q;
   assign S_AXI_ARREADY = ~rvalid_q;
   assign S_AXI_RVALID  = rvalid_q;
   assign S_AXI_RDATA   = rdata_q;
   assign S_AXI_RRESP   = rresp_q;
   assign CORE_SKIP     = skip_q;
   assign CORE_STALL    = stall_q;
   assign FLASH_ADDR    = faddr_q;
   assign FLASH_RD_EN   = rd_en_q;
   assign FLASH_ERASE   = erase_q;
   assign FLASH_PROG_EN = prog_q;
   assign FLASH_WDATA   = fwdata_q;

   assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
   assign rd_fire = S_AXI_ARVALID & ~rvalid_q;
   assign wbyte   = w_strb_q[0] ? w_data_q[7:0] : 8'h00;
   assign ctl_wr  = wr_fire & (aw_addr_q == `OFS_CONTROL) & w_strb_q[0];

   // Go only with enable already set, a fresh key and an idle sequencer
   assign go_ok = ctl_wr & wbyte[`BIT_GO] & program_enable_latch_q
                  & (key_q == KEY_FULL)
                  & (state_q == ST_IDLE) & ~program_go_q & ~read_start_q;

   assign word_addr    = {addr_high_reg_q, addr_low_reg_q};
   assign flash_target = program_space_select_q & ~config_space_select_q;

   always @* begin
      case (wrt_sync_q)
         2'b11:   prot_limit = `PROT_NONE;
         2'b10:   prot_limit = `PROT_BOOT;
         2'b01:   prot_limit = `PROT_HALF;
         default: prot_limit = `PROT_ALL;
      endcase
   end

   // Addresses below the limit belong to the protected segment
   assign protected_hit = (wrt_sync_q == 2'b00) ||
                          (word_addr[12:0] < prot_limit);

   // Latch load happens in every unprotected flash-target non-erase go, latch-only or commit
   assign latch_load = (state_q == ST_IDLE) & program_go_q & flash_target
                       & ~protected_hit & ~row_erase_select_q;
   assign latch_fill = (state_q == ST_WAIT) & t_done & ~op_erase_q;
   assign t_start    = ((state_q == ST_SETUP) & (setup_q == `SETUP_CYCLES)
                        & op_erase_q)
                       | ((state_q == ST_PROG) & (idx_q == `LAST_LATCH));

   write_latch_bank latches (
      .clk       (CORE_CLK),
      .rst       (RST),
      .load_en   (latch_load),
      .load_idx  (word_addr[4:0]),
      .load_data ({data_high_reg_q, data_low_reg_q}),
      .fill_all  (latch_fill),
      .rd_idx    (idx_q),
      .rd_data   (latch_rdata)
   );

   busy_timer #(
      .CYCLES (PROG_CYCLES)
   ) pulse_timer (
      .clk   (CORE_CLK),
      .rst   (RST),
      .start (t_start),
      .done  (t_done)
   );

   always @* begin
      rd_hit = 1'b1;
      case (S_AXI_ARADDR)
         `OFS_ADDR_LOW:  rd_mux = {24'h00_0000, addr_low_reg_q};
         `OFS_ADDR_HIGH: rd_mux = {25'h000_0000, addr_high_reg_q};
         `OFS_DATA_LOW:  rd_mux = {24'h00_0000, data_low_reg_q};
         `OFS_DATA_HIGH: rd_mux = {26'h000_0000, data_high_reg_q};
         `OFS_CONTROL:   rd_mux = {24'h00_0000, program_space_select_q,
                                   config_space_select_q, latch_only_mode_q,
                                   row_erase_select_q, 1'b0,
                                   program_enable_latch_q, program_go_q,
                                   read_start_q};
         `OFS_UNLOCK:    rd_mux = 32'h0000_0000;
         default: begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always @(posedge CORE_CLK) begin
      wrt_meta_q <= WRT_PROT;
      wrt_sync_q <= wrt_meta_q;
   end

   // Write address and data are taken in either order
   always @(posedge CORE_CLK) begin
      if (RST) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_held_q  <= 1'b0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `RESP_OKAY;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && !aw_held_q) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
         end else if (wr_fire) begin
            aw_held_q <= 1'b0;
         end
         if (S_AXI_WVALID && !w_held_q) begin
            w_held_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
         end else if (wr_fire) begin
            w_held_q <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (aw_addr_q > `OFS_UNLOCK || aw_addr_q[1:0] != 2'b00)
                        ? `RESP_SLVERR : `RESP_OKAY;
         end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
         end
         if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // Register file and unlock tracking
   always @(posedge CORE_CLK) begin
      if (RST) begin
         addr_low_reg_q         <= 8'h00;
         addr_high_reg_q        <= 7'h00;
         data_low_reg_q         <= 8'h00;
         data_high_reg_q        <= 6'h00;
         read_start_q           <= 1'b0;
         program_go_q           <= 1'b0;
         program_enable_latch_q <= 1'b0;
         row_erase_select_q     <= 1'b0;
         latch_only_mode_q      <= 1'b0;
         config_space_select_q  <= 1'b0;
         program_space_select_q <= 1'b0;
         key_q                  <= KEY_NONE;
      end else begin
         // Any other bus write between key and go breaks the sequence
         if (wr_fire) begin
            if (aw_addr_q == `OFS_UNLOCK && wbyte == `KEY_FIRST) begin
               key_q <= KEY_HALF;
            end else if (aw_addr_q == `OFS_UNLOCK && wbyte == `KEY_SECOND
                         && key_q == KEY_HALF) begin
               key_q <= KEY_FULL;
            end else begin
               key_q <= KEY_NONE;
            end
         end
         if (wr_fire && w_strb_q[0]) begin
            case (aw_addr_q)
               `OFS_ADDR_LOW:  addr_low_reg_q  <= wbyte;
               `OFS_ADDR_HIGH: addr_high_reg_q <= wbyte[6:0];
               `OFS_DATA_LOW:  data_low_reg_q  <= wbyte;
               `OFS_DATA_HIGH: data_high_reg_q <= wbyte[5:0];
               default: begin
               end
            endcase
         end
         // Mode bits frozen while an operation runs
         if (ctl_wr) begin
            program_enable_latch_q <= wbyte[`BIT_PROGRAM_ENABLE_LATCH];
            if (state_q == ST_IDLE && !program_go_q && !read_start_q) begin
               row_erase_select_q     <= wbyte[`BIT_ERASE];
               latch_only_mode_q      <= wbyte[`BIT_LATCH];
               config_space_select_q  <= wbyte[`BIT_CONFIG_SPACE_SELECT];
               program_space_select_q <= wbyte[`BIT_PGD];
            end
         end
         // Writing zero never clears these; only hardware does
         if (ctl_wr && wbyte[`BIT_READ] && state_q == ST_IDLE && !program_go_q) begin
            read_start_q <= 1'b1;
         end else if (state_q == ST_RDCAP ||
                      (state_q == ST_IDLE && read_start_q && !flash_target)) begin
            read_start_q <= 1'b0;
         end
         if (go_ok) begin
            program_go_q <= 1'b1;
         end else if ((state_q == ST_WAIT && t_done) ||
                      (state_q == ST_IDLE && program_go_q &&
                       (!flash_target || protected_hit ||
                        (latch_only_mode_q && !row_erase_select_q)))) begin
            program_go_q <= 1'b0;
         end
         if (state_q == ST_WAIT && t_done && op_erase_q) begin
            row_erase_select_q <= 1'b0;
         end
         // Read result replaces data registers
         if (state_q == ST_RDCAP) begin
            data_low_reg_q  <= FLASH_RDATA[7:0];
            data_high_reg_q <= FLASH_RDATA[13:8];
         end
      end
   end

   // Sequencer
   always @(posedge CORE_CLK) begin
      if (RST) begin
         state_q    <= ST_IDLE;
         setup_q    <= 2'h0;
         idx_q      <= 5'h00;
         op_erase_q <= 1'b0;
         stall_q    <= 1'b0;
         skip_q     <= 1'b0;
         rd_en_q    <= 1'b0;
         erase_q    <= 1'b0;
         prog_q     <= 1'b0;
         faddr_q    <= 15'h0000;
         fwdata_q   <= 14'h0000;
      end else begin
         erase_q <= 1'b0;
         prog_q  <= 1'b0;
         rd_en_q <= 1'b0;
         skip_q  <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               setup_q <= 2'h0;
               idx_q   <= 5'h00;
               if (program_go_q && flash_target && !protected_hit) begin
                  // Erase and commit take setup; latch-only returns at once
                  if (row_erase_select_q) begin
                     op_erase_q <= 1'b1;
                     state_q    <= ST_SETUP;
                  end else if (!latch_only_mode_q) begin
                     op_erase_q <= 1'b0;
                     state_q    <= ST_SETUP;
                  end
               end else if (read_start_q && flash_target) begin
                  // Code protection does not gate reads
                  rd_en_q <= 1'b1;
                  skip_q  <= 1'b1;
                  faddr_q <= word_addr;
                  state_q <= ST_RDISS;
               end
            end
            ST_RDISS: begin
               state_q <= ST_RDCAP;
            end
            ST_RDCAP: begin
               state_q <= ST_IDLE;
            end
            ST_SETUP: begin
               setup_q <= setup_q + 2'h1;
               if (setup_q == `SETUP_CYCLES) begin
                  stall_q <= 1'b1;
                  if (op_erase_q) begin
                     // Row boundary only; a row is the least erase unit
                     faddr_q <= {word_addr[14:5], 5'h00};
                     erase_q <= 1'b1;
                     state_q <= ST_WAIT;
                  end else begin
                     state_q <= ST_PROG;
                  end
               end
            end
            ST_PROG: begin
               // Whole aligned block streamed, no erase ahead of it
               prog_q   <= 1'b1;
               faddr_q  <= {word_addr[14:5], idx_q};
               fwdata_q <= latch_rdata;
               idx_q    <= idx_q + 5'h01;
               if (idx_q == `LAST_LATCH) begin
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (t_done) begin
                  stall_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

/* File: hw/write_latch_bank.v */
// Bank of 32 fourteen-bit write latches
`timescale 1ns/1ps
module write_latch_bank (
   input  wire        clk,
   input  wire        rst,
   input  wire        load_en,
   input  wire [4:0]  load_idx,
   input  wire [13:0] load_data,
   input  wire        fill_all,
   input  wire [4:0]  rd_idx,
   output wire [13:0] rd_data
);
`include "flash_seq_regs.vh"
   reg [13:0] latch_q [0:`LATCH_COUNT-1];
   integer i;

   assign rd_data = latch_q[rd_idx];

   always @(posedge clk) begin
      for (i = 0; i < `LATCH_COUNT; i = i + 1) begin
         if (rst || fill_all) begin
            latch_q[i] <= `LATCH_ERASED;
         end else if (load_en && load_idx == i[4:0]) begin
            latch_q[i] <= load_data;
         end
      end
   end
endmodule

/* File: tb/flash_array_model.sv */
// Behavioural program flash array behind the sequencer
`timescale 1ns/1ps
module flash_array_model (
   input  wire logic        clk,
   input  wire logic [14:0] addr,
   input  wire logic        rd_en,
   input  wire logic        erase,
   input  wire logic        prog_en,
   input  wire logic [13:0] wdata,
   output logic      [13:0] rdata
);
   logic [13:0] mem [0:32767];
   int          rd_count = 0;
   int          erase_count = 0;
   int          prog_count = 0;
   initial begin
      for (int i = 0; i < 32768; i++) mem[i] = 14'h3fff;
      mem[15'h1234] = 14'h2a5c;
      mem[15'h0045] = 14'h0000;
      rdata = 14'h0000;
   end
   always @(posedge clk) begin
      // Word valid only the cycle after the strobe; toggles otherwise
      rdata <= rd_en ? mem[addr] : ~rdata;
      if (rd_en) rd_count <= rd_count + 1;
      if (erase) begin
         for (int i = 0; i < 32; i++) mem[{addr[14:5], i[4:0]}] <= 14'h3fff;
         erase_count <= erase_count + 1;
      end
      if (prog_en) begin
         // Cells only clear, so a write never erases
         mem[addr] <= mem[addr] & wdata;
         prog_count <= prog_count + 1;
      end
   end
endmodule

/* File: tb/flash_seq_asserts.sv */
// Port-level concurrent checks for the program flash sequencer
`timescale 1ns/1ps
module flash_seq_asserts #(
   parameter PROG_CYCLES = 20
) (
   input wire logic        CORE_CLK,
   input wire logic        RST,
   input wire logic        CORE_SKIP,
   input wire logic        CORE_STALL,
   input wire logic [14:0] FLASH_ADDR,
   input wire logic        FLASH_RD_EN,
   input wire logic        FLASH_ERASE,
   input wire logic        FLASH_PROG_EN,
   input wire logic [1:0]  WRT_PROT
);
   // Commit stalls through 32 word pulses plus the timer
   localparam int STALL_MAX = PROG_CYCLES + 60;
   logic [5:0] burst_q;
   logic [5:0] prot_q;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   always @(posedge CORE_CLK) begin
      if (RST) begin
         burst_q <= 6'h00;
         prot_q  <= 6'h00;
      end else begin
         burst_q <= FLASH_PROG_EN ? burst_q + 6'h01 : 6'h00;
         // Saturates so a long protected spell never wraps
         prot_q  <= (WRT_PROT != 2'b00) ? 6'h00 : (prot_q == 6'h3f) ? prot_q : prot_q + 6'h01;
      end
   end
   sequence read_strobe;
      FLASH_RD_EN && CORE_SKIP && !CORE_STALL;
   endsequence
   sequence strobes_drop;
      !FLASH_RD_EN && !CORE_SKIP;
   endsequence
   sequence erase_start;
      CORE_STALL && FLASH_ADDR[4:0] == 5'h00;
   endsequence
   read_skip_a: assert property (FLASH_RD_EN |-> read_strobe ##1 strobes_drop)
      else $error("read strobe without one-cycle skip");
   skip_cause_a: assert property (CORE_SKIP |-> FLASH_RD_EN)
      else $error("skip without flash read");
   erase_row_a: assert property (FLASH_ERASE |-> erase_start ##1 (!FLASH_ERASE && CORE_STALL))
      else $error("erase not row aligned or not stalled");
   stall_min_a: assert property ($rose(CORE_STALL) |-> CORE_STALL[*8])
      else $error("stall too short");
   stall_max_a: assert property ($rose(CORE_STALL) |-> ##[1:STALL_MAX] !CORE_STALL)
      else $error("stall never ends");
   prog_stall_a: assert property (FLASH_PROG_EN |-> CORE_STALL)
      else $error("programming without stall");
   prog_start_a: assert property ($rose(FLASH_PROG_EN) |-> FLASH_ADDR[4:0] == 5'h00)
      else $error("block write not aligned");
   prog_step_a: assert property (FLASH_PROG_EN && $past(FLASH_PROG_EN)
      |-> FLASH_ADDR == $past(FLASH_ADDR) + 15'h0001)
      else $error("block write address not consecutive");
   burst_len_a: assert property ($fell(FLASH_PROG_EN) |-> burst_q == 6'h20)
      else $error("block write not 32 words");
   protect_a: assert property (prot_q == 6'h3f |-> !FLASH_ERASE && !FLASH_PROG_EN)
      else $error("flash changed while protected");
endmodule

/* File: tb/program_flash_access_sequencer_tb_top.sv */
// Self-checking bench for the program flash sequencer
`timescale 1ns/1ps
`include "flash_seq_regs.vh"
module program_flash_access_sequencer_tb_top;
   localparam int PROG_CYCLES = 20;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [1:0]  wrt_prot = 2'b11;
   wire         awready, wready, bvalid, arready, rvalid, skip, stall, rd_en, erase, prog_en;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [14:0] faddr;
   wire  [13:0] frdata, fwdata;
   int          mismatches = 0, cmp_count = 0, skip_cnt = 0, stall_cnt = 0;
   always #4 clk = ~clk;
   always @(posedge clk) begin
      skip_cnt  <= skip_cnt + skip;
      stall_cnt <= stall_cnt + stall;
   end
   flash_seq #(.PROG_CYCLES(PROG_CYCLES)) dut (
      .CORE_CLK(clk),              .RST(rst),
      .S_AXI_AWADDR(awaddr),       .S_AXI_AWVALID(awvalid),  .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata),         .S_AXI_WSTRB(4'hf),       .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready),       .S_AXI_BRESP(bresp),      .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready),       .S_AXI_ARADDR(araddr),    .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready),     .S_AXI_RDATA(rdata),      .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid),       .S_AXI_RREADY(rready),    .CORE_SKIP(skip),
      .CORE_STALL(stall),          .FLASH_ADDR(faddr),       .FLASH_RD_EN(rd_en),
      .FLASH_RDATA(frdata),        .FLASH_ERASE(erase),      .FLASH_PROG_EN(prog_en),
      .FLASH_WDATA(fwdata),        .WRT_PROT(wrt_prot)
   );
   flash_array_model model (.clk(clk), .addr(faddr), .rd_en(rd_en), .erase(erase),
      .prog_en(prog_en), .wdata(fwdata), .rdata(frdata));
   task automatic tally_and_finish;
      if (mismatches == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         mismatches++;
      end
   endtask
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (awvalid || wvalid || !bvalid) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      chk("bresp", `RESP_OKAY, bresp);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(nm, e, d);
   endtask
   task automatic go(input logic [31:0] ctl);
      wr(`OFS_UNLOCK, 32'h0000_0055);
      wr(`OFS_UNLOCK, 32'h0000_00aa);
      wr(`OFS_CONTROL, ctl);
      repeat (2) @(posedge clk);
   endtask
   // No fixed latency is assumed; the watchdog bounds this poll
   task automatic poll(output logic [31:0] d);
      logic [1:0] r;
      do rd(`OFS_CONTROL, d, r); while (d[1]);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      tally_and_finish();
   end
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      int          s0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rc("control reset", `OFS_CONTROL, 32'h0000_0000);
      rd(8'h18, d, r);
      chk("unmapped resp", 32'h0000_0002, {30'h0000_0000, r});
      wr(`OFS_ADDR_HIGH, 32'h0000_0012);
      wr(`OFS_ADDR_LOW, 32'h0000_0034);
      wr(`OFS_DATA_LOW, 32'h0000_0011);
      wr(`OFS_CONTROL, 32'h0000_0001);
      wr(`OFS_CONTROL, 32'h0000_00c1);
      rc("eeprom data", `OFS_DATA_LOW, 32'h0000_0011);
      chk("foreign space reads", 32'h0000_0000, model.rd_count);
      wr(`OFS_CONTROL, 32'h0000_0081);
      repeat (2) @(posedge clk);
      rc("read low", `OFS_DATA_LOW, 32'h0000_005c);
      rc("read high", `OFS_DATA_HIGH, 32'h0000_002a);
      rc("read start clear", `OFS_CONTROL, 32'h0000_0080);
      chk("skip pulses", 32'h0000_0001, skip_cnt);
      chk("flash reads", 32'h0000_0001, model.rd_count);
      go(32'h0000_0082);
      rc("go without enable", `OFS_CONTROL, 32'h0000_0080);
      wr(`OFS_CONTROL, 32'h0000_0084);
      wr(`OFS_CONTROL, 32'h0000_0086);
      rc("go without key", `OFS_CONTROL, 32'h0000_0084);
      wr(`OFS_UNLOCK, 32'h0000_00aa);
      wr(`OFS_UNLOCK, 32'h0000_0055);
      wr(`OFS_CONTROL, 32'h0000_0086);
      rc("key reversed", `OFS_CONTROL, 32'h0000_0084);
      rc("data held", `OFS_DATA_LOW, 32'h0000_005c);
      wr(`OFS_ADDR_HIGH, 32'h0000_0000);
      wr(`OFS_ADDR_LOW, 32'h0000_0045);
      wr(`OFS_CONTROL, 32'h0000_0094);
      s0 = stall_cnt;
      go(32'h0000_0096);
      poll(d);
      chk("erase select clear", 32'h0000_0084, d);
      chk("erase count", 32'h0000_0001, model.erase_count);
      chk("erased word", 32'h0000_3fff, model.mem[15'h0045]);
      chk("erase stall", 32'h0000_0001, stall_cnt - s0 >= PROG_CYCLES);
      wr(`OFS_CONTROL, 32'h0000_00a4);
      wr(`OFS_DATA_HIGH, 32'h0000_0005);
      s0 = stall_cnt;
      for (int i = 0; i < 3; i++) begin
         wr(`OFS_ADDR_LOW, 32'h0000_0040 + i);
         wr(`OFS_DATA_LOW, 32'h0000_0001 + i);
         go(32'h0000_00a6);
         rc("latch go clear", `OFS_CONTROL, 32'h0000_00a4);
      end
      chk("latch stall", s0, stall_cnt);
      chk("latch no program", 32'h0000_0000, model.prog_count);
      wr(`OFS_CONTROL, 32'h0000_0084);
      wr(`OFS_ADDR_LOW, 32'h0000_0043);
      wr(`OFS_DATA_LOW, 32'h0000_0004);
      s0 = stall_cnt;
      go(32'h0000_0086);
      poll(d);
      for (int i = 0; i < 32; i++)
         chk("block word", i < 4 ? 32'h0000_0501 + i : 32'h0000_3fff, model.mem[64 + i]);
      chk("program count", 32'h0000_0020, model.prog_count);
      chk("no auto erase", 32'h0000_0001, model.erase_count);
      chk("commit stall", 32'h0000_0001, stall_cnt - s0 >= PROG_CYCLES);
      wr(`OFS_ADDR_LOW, 32'h0000_0060);
      wr(`OFS_DATA_LOW, 32'h0000_00bc);
      wr(`OFS_DATA_HIGH, 32'h0000_000a);
      go(32'h0000_0086);
      poll(d);
      for (int i = 0; i < 32; i++)
         chk("latch reset", i == 0 ? 32'h0000_0abc : 32'h0000_3fff, model.mem[96 + i]);
      wrt_prot <= 2'b00;
      wr(`OFS_ADDR_LOW, 32'h0000_0040);
      wr(`OFS_CONTROL, 32'h0000_0094);
      go(32'h0000_0096);
      poll(d);
      chk("protected go", 32'h0000_0094, d);
      chk("protected erase", 32'h0000_0001, model.erase_count);
      chk("protected word", 32'h0000_0501, model.mem[15'h0040]);
      wrt_prot <= 2'b11;
      tally_and_finish();
   end
endmodule
bind flash_seq flash_seq_asserts #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
   .CORE_CLK(CORE_CLK), .RST(RST), .CORE_SKIP(CORE_SKIP), .CORE_STALL(CORE_STALL),
   .FLASH_ADDR(FLASH_ADDR), .FLASH_RD_EN(FLASH_RD_EN), .FLASH_ERASE(FLASH_ERASE),
   .FLASH_PROG_EN(FLASH_PROG_EN), .WRT_PROT(WRT_PROT));
